// *** pkg/pfb_pkg.sv ***
// Package: timing constants, states and the cycle conversion function for the parallel flash sequencer
package pfb_pkg;

  // ----------------------------------------------------------------
  // Clock and interval units
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned CLK_FREQ_MHZ  = 125;

  // Unit codes for setup, wait and hold figures
  typedef enum logic [1:0] {
    PFB_UNIT_NS,
    PFB_UNIT_US,
    PFB_UNIT_MS,
    PFB_UNIT_CYC
  } pfb_unit_t;

  // Default interval figures, in the default unit
  localparam int unsigned SETUP_DEFAULT = 40;
  localparam int unsigned WAIT_DEFAULT  = 160;
  localparam int unsigned HOLD_DEFAULT  = 40;
  localparam int unsigned CNT_W         = 24;

  // Default flash geometry
  localparam int unsigned FLASH_AW_DEFAULT = 22;
  localparam int unsigned FLASH_DW_DEFAULT = 16;
  localparam int unsigned HOST_DW_DEFAULT  = 32;

  // Sequencer states
  typedef enum logic [2:0] {
    PFB_IDLE,
    PFB_SETUP,
    PFB_STROBE,
    PFB_HOLD,
    PFB_DONE
  } pfb_state_t;

  // Time to whole cycles, rounding up, at least one
  function automatic int unsigned pfb_cycles(input int unsigned value, input pfb_unit_t unit);
    longint unsigned ps;
    longint unsigned cyc;
    ps  = 0;
    cyc = 0;
    case (unit)
      PFB_UNIT_NS: ps = longint'(value) * 64'd1000;
      PFB_UNIT_US: ps = longint'(value) * 64'd1000000;
      PFB_UNIT_MS: ps = longint'(value) * 64'd1000000000;
      default:     ps = 64'd0;
    endcase
    if (unit == PFB_UNIT_CYC)
    begin
      cyc = longint'(value);
    end
    else
    begin
      cyc = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    end
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return int'(cyc);
  endfunction : pfb_cycles

endpackage : pfb_pkg

// *** rtl/pfb_flash_seq.sv ***
// Parallel flash sequencer: host memory port to tristate flash pins
`timescale 1ns/1ns
module pfb_flash_seq #(
  parameter int unsigned      FLASH_AW  = pfb_pkg::FLASH_AW_DEFAULT,
  parameter int unsigned      FLASH_DW  = pfb_pkg::FLASH_DW_DEFAULT,
  parameter int unsigned      HOST_DW   = pfb_pkg::HOST_DW_DEFAULT,
  parameter pfb_pkg::pfb_unit_t UNIT    = pfb_pkg::PFB_UNIT_NS,
  parameter int unsigned      SETUP_VAL = pfb_pkg::SETUP_DEFAULT,
  parameter int unsigned      WAIT_VAL  = pfb_pkg::WAIT_DEFAULT,
  parameter int unsigned      HOLD_VAL  = pfb_pkg::HOLD_DEFAULT,
  parameter int unsigned      LANES     = HOST_DW / FLASH_DW,
  parameter int unsigned      LANE_W    = (LANES > 1) ? $clog2(LANES) : 1,
  parameter int unsigned      HOST_AW   = FLASH_AW + ((LANES > 1) ? $clog2(LANES) : 0)
) (
  input  wire logic                clock_in,
  input  wire logic                rstn_in,
  // Host memory port, one word per request, address in flash words
  input  wire logic                host_read_in,
  input  wire logic                host_write_in,
  input  wire logic [HOST_AW-1:0]  host_addr_in,
  input  wire logic [HOST_DW-1:0]  host_wdata_in,
  output logic                     host_waitreq_out,
  output logic                     host_rvalid_out,
  output logic [HOST_DW-1:0]       host_rdata_out,
  // Shared tristate pins plus dedicated strobes
  output logic [FLASH_AW-1:0]      flash_addr_out,
  input  wire logic [FLASH_DW-1:0] flash_data_in,
  output logic [FLASH_DW-1:0]      flash_data_out,
  output logic                     flash_data_oe_out,
  output logic                     flash_cs_n_out,
  output logic                     flash_rd_n_out,
  output logic                     flash_wr_n_out
);

  // ----------------------------------------------------------------
  // Interval counts
  // ----------------------------------------------------------------
  // Converted once at elaboration; rounding up never shortens a phase
  localparam int unsigned SETUP_CYC = pfb_pkg::pfb_cycles(SETUP_VAL, UNIT);
  localparam int unsigned WAIT_CYC  = pfb_pkg::pfb_cycles(WAIT_VAL, UNIT);
  localparam int unsigned HOLD_CYC  = pfb_pkg::pfb_cycles(HOLD_VAL, UNIT);
  localparam logic [pfb_pkg::CNT_W-1:0] SETUP_LAST = pfb_pkg::CNT_W'(SETUP_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] WAIT_LAST  = pfb_pkg::CNT_W'(WAIT_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] HOLD_LAST  = pfb_pkg::CNT_W'(HOLD_CYC - 1);
  localparam int unsigned LANE_LAST = LANES - 1;
  localparam int unsigned WAIT_PRE  = WAIT_CYC + 1;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  pfb_pkg::pfb_state_t         state;
  pfb_pkg::pfb_state_t         next_state;
  logic [pfb_pkg::CNT_W-1:0]   cnt;
  logic [pfb_pkg::CNT_W-1:0]   next_cnt;
  logic [LANE_W-1:0]           lane;
  logic [LANE_W-1:0]           next_lane;
  logic                        is_write;
  logic                        next_is_write;
  logic [FLASH_AW-1:0]         base;
  logic [FLASH_AW-1:0]         next_base;
  logic [HOST_DW-1:0]          wbuf;
  logic [HOST_DW-1:0]          next_wbuf;
  logic [HOST_DW-1:0]          rbuf;
  logic [HOST_DW-1:0]          next_rbuf;
  logic                        rvalid;
  logic                        next_rvalid;

  // Next-state logic: one beat per flash lane, host held in wait
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_lane     = lane;
    next_is_write = is_write;
    next_base     = base;
    next_wbuf     = wbuf;
    next_rbuf     = rbuf;
    next_rvalid   = 1'b0;
    case (state)
      pfb_pkg::PFB_IDLE:
      begin
        // Only raw transfers; command sequences come from software
        if (host_read_in || host_write_in)
        begin
          next_state    = pfb_pkg::PFB_SETUP;
          next_cnt      = '0;
          next_lane     = '0;
          next_is_write = host_write_in;
          next_base     = host_addr_in[FLASH_AW-1:0];
          next_wbuf     = host_wdata_in;
        end
      end
      pfb_pkg::PFB_SETUP:
      begin
        // Select is low, strobe waits
        if (cnt == SETUP_LAST)
        begin
          next_state = pfb_pkg::PFB_STROBE;
          next_cnt   = '0;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      pfb_pkg::PFB_STROBE:
      begin
        // Strobe width; data sampled in the last strobe cycle
        if (cnt == WAIT_LAST)
        begin
          next_state = pfb_pkg::PFB_HOLD;
          next_cnt   = '0;
          if (!is_write)
          begin
            next_rbuf = {flash_data_in, rbuf[HOST_DW-1:FLASH_DW]};
          end
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      pfb_pkg::PFB_HOLD:
      begin
        // Select held after strobe release
        if (cnt == HOLD_LAST)
        begin
          next_cnt = '0;
          if (lane == LANE_W'(LANE_LAST))
          begin
            next_state  = pfb_pkg::PFB_DONE;
            next_rvalid = !is_write;
          end
          else
          begin
            // Next narrow lane, low lane first
            next_state = pfb_pkg::PFB_SETUP;
            next_lane  = lane + 1'b1;
            next_wbuf  = wbuf >> FLASH_DW;
          end
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      pfb_pkg::PFB_DONE:
      begin
        next_state = pfb_pkg::PFB_IDLE;
      end
      default:
      begin
        next_state = pfb_pkg::PFB_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state    <= pfb_pkg::PFB_IDLE;
      cnt      <= '0;
      lane     <= '0;
      is_write <= 1'b0;
      base     <= '0;
      wbuf     <= '0;
      rbuf     <= '0;
      rvalid   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      lane     <= next_lane;
      is_write <= next_is_write;
      base     <= next_base;
      wbuf     <= next_wbuf;
      rbuf     <= next_rbuf;
      rvalid   <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Pin and host outputs
  // ----------------------------------------------------------------
  // Pins decoded from registered state, so they are glitch free
  logic in_cycle;
  assign in_cycle          = (state == pfb_pkg::PFB_SETUP) || (state == pfb_pkg::PFB_STROBE)
                             || (state == pfb_pkg::PFB_HOLD);
  assign flash_cs_n_out    = !in_cycle;
  assign flash_rd_n_out    = !((state == pfb_pkg::PFB_STROBE) && !is_write);
  assign flash_wr_n_out    = !((state == pfb_pkg::PFB_STROBE) && is_write);
  // Data driven for the whole write select window, released otherwise
  assign flash_data_oe_out = in_cycle && is_write;
  assign flash_data_out    = wbuf[FLASH_DW-1:0];
  // Lane added to the base address, so narrow beats walk upward
  assign flash_addr_out    = (LANES > 1) ? FLASH_AW'(base + FLASH_AW'(lane)) : base;
  assign host_waitreq_out  = (state != pfb_pkg::PFB_DONE);
  assign host_rvalid_out   = rvalid;
  assign host_rdata_out    = rbuf;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Phases measured on the pins, so a state slip cannot hide
  logic strobe_idle;
  assign strobe_idle = flash_rd_n_out && flash_wr_n_out;

  property p_setup_before_strobe;
    @(posedge clock_in) disable iff (!rstn_in)
    $fell(strobe_idle) |-> $past(!flash_cs_n_out && strobe_idle, SETUP_CYC);
  endproperty
  a_setup_before_strobe: assert property (p_setup_before_strobe)
    else $error("strobe asserted together with select");

  property p_strobe_width;
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(strobe_idle) |->
      $past(!strobe_idle, WAIT_CYC) && $past(strobe_idle, WAIT_PRE);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe left before wait count");

  property p_hold_select;
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(flash_wr_n_out) |-> !flash_cs_n_out;
  endproperty
  a_hold_select: assert property (p_hold_select)
    else $error("select released with write strobe");

  property p_hold_len;
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(flash_cs_n_out) |-> $past(!flash_cs_n_out && strobe_idle, HOLD_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("select released before hold count");

  property p_one_strobe;
    @(posedge clock_in) disable iff (!rstn_in)
    !(!flash_rd_n_out && !flash_wr_n_out);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobe both low");

  property p_strobe_in_select;
    @(posedge clock_in) disable iff (!rstn_in)
    (!flash_rd_n_out || !flash_wr_n_out) |-> !flash_cs_n_out;
  endproperty
  a_strobe_in_select: assert property (p_strobe_in_select)
    else $error("strobe outside select");

  property p_oe_write_only;
    @(posedge clock_in) disable iff (!rstn_in)
    flash_data_oe_out |-> (is_write && !flash_cs_n_out);
  endproperty
  a_oe_write_only: assert property (p_oe_write_only)
    else $error("data driven outside write");

  property p_rvalid_after_read;
    @(posedge clock_in) disable iff (!rstn_in)
    host_rvalid_out |-> ($past(state) == pfb_pkg::PFB_HOLD && !is_write);
  endproperty
  a_rvalid_after_read: assert property (p_rvalid_after_read)
    else $error("read data without read cycle");

  property p_lane_bound;
    @(posedge clock_in) disable iff (!rstn_in)
    (state == pfb_pkg::PFB_DONE) |-> (lane == LANE_W'(LANE_LAST));
  endproperty
  a_lane_bound: assert property (p_lane_bound)
    else $error("transfer ended before all lanes");

  c_read:  cover property (@(posedge clock_in) disable iff (!rstn_in) host_rvalid_out);
  c_write: cover property (@(posedge clock_in) disable iff (!rstn_in) $rose(flash_wr_n_out));
  c_back:  cover property (@(posedge clock_in) disable iff (!rstn_in)
                           state == pfb_pkg::PFB_DONE ##2 state == pfb_pkg::PFB_SETUP);

endmodule : pfb_flash_seq

// *** testbench/parallel_flash_bus_timing_tb.sv ***
// Self-checking bench for the parallel flash sequencer
`timescale 1ns/1ns
module parallel_flash_bus_timing_tb;
  localparam int S = 2;
  localparam int W = 3;
  localparam int H = 1;
  localparam int LAT = 2 * (S + W + H) + 2;  // Two lanes, counted from the driving edge
  logic        clock_in, rstn_in, rd, wr, waitreq, rvalid, oe, cs_n, rd_n, wr_n;
  logic [8:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  f_addr;
  logic [15:0] f_din, f_dout;
  logic [5:0]  ns_pins;
  logic [7:0]  ns_addr;
  logic [15:0] ns_dout;
  logic [31:0] ns_rdata;
  logic [31:0] gap, wid, cyc;
  logic        seen, p_cs, p_sb;
  int          errors, n_compared, lat;
  // ----------------------------------------------------------------
  // Clock, design under test and flash model
  // ----------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  pfb_flash_seq #(.FLASH_AW(8), .UNIT(pfb_pkg::PFB_UNIT_CYC), .SETUP_VAL(S), .WAIT_VAL(W),
    .HOLD_VAL(H)) dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .host_read_in(rd),
    .host_write_in(wr), .host_addr_in(addr), .host_wdata_in(wdata), .host_waitreq_out(waitreq),
    .host_rvalid_out(rvalid), .host_rdata_out(rdata), .flash_addr_out(f_addr),
    .flash_data_in(f_din), .flash_data_out(f_dout), .flash_data_oe_out(oe),
    .flash_cs_n_out(cs_n), .flash_rd_n_out(rd_n), .flash_wr_n_out(wr_n));
  // Same timing given in ns (9/17/1 ns round up to 2/3/1 cycles) must move in lockstep
  pfb_flash_seq #(.FLASH_AW(8), .UNIT(pfb_pkg::PFB_UNIT_NS), .SETUP_VAL(9), .WAIT_VAL(17),
    .HOLD_VAL(1)) dut_ns_u (.clock_in(clock_in), .rstn_in(rstn_in), .host_read_in(rd),
    .host_write_in(wr), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_waitreq_out(ns_pins[5]), .host_rvalid_out(ns_pins[4]), .host_rdata_out(ns_rdata),
    .flash_addr_out(ns_addr), .flash_data_in(f_din), .flash_data_out(ns_dout),
    .flash_data_oe_out(ns_pins[3]), .flash_cs_n_out(ns_pins[2]), .flash_rd_n_out(ns_pins[1]),
    .flash_wr_n_out(ns_pins[0]));
  pfb_flash_model #(.AW(8), .DW(16)) flash_u (.cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_in(f_addr), .data_in(f_dout), .data_oe_in(oe), .data_out(f_din));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Phase monitor: setup, strobe and hold lengths seen on the pins
  always @(posedge clock_in)
  begin
    if (rstn_in)
    begin
      check({26'h0, ns_pins}, {26'h0, waitreq, rvalid, oe, cs_n, rd_n, wr_n});
      check({8'h0, ns_addr, ns_dout}, {8'h0, f_addr, f_dout});
      check(ns_rdata, rdata);
      if (!rd_n)
        check(32'(oe), 32'h0);
      if (!(rd_n & wr_n) && p_sb)
      begin
        check(gap, seen ? 32'(S + H) : 32'(S));
        gap = 0;
        seen = 1'b1;
      end
      if ((rd_n & wr_n) && !p_sb)
      begin
        check(wid, 32'(W));
        wid = 0;
      end
      if (cs_n && !p_cs)
      begin
        check(gap, 32'(H));
        gap = 0;
        seen = 1'b0;
      end
      if (!cs_n && (rd_n & wr_n))
        gap++;
      if (!(rd_n & wr_n))
        wid++;
    end
    p_cs = cs_n;
    p_sb = rd_n & wr_n;
    cyc++;
    if (cyc == 32'd2000)
    begin
      errors++;
      print_verdict();
    end
  end
  // One host transfer: hold the request until waitreq is seen low
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clock_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    lat = 0;
    do
    begin
      @(posedge clock_in);
      lat++;
    end while (waitreq !== 1'b0 && lat < 100);
    q = rdata;
    check(32'(rvalid), 32'(!w));
    check(32'(lat), 32'(LAT));
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({28'h0, waitreq, cs_n, rvalid, oe}, 32'hC);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write();
    xfer(1'b1, 9'h010, 32'h1234ABCD);
    xfer(1'b1, 9'h012, 32'h5678EF01);
    check({16'h0, flash_u.mem[8'h10]}, 32'hABCD);
    check({16'h0, flash_u.mem[8'h11]}, 32'h1234);
    check({16'h0, flash_u.mem[8'h13]}, 32'h5678);
    $display("write test done");
  endtask : t_write
  task automatic t_read();
    xfer(1'b0, 9'h010, 32'h0);
    check(q, 32'h1234ABCD);
    xfer(1'b0, 9'h0FE, 32'h0);
    check(q, 32'hA5FFA5FE);
    $display("read test done");
  endtask : t_read
  initial
  begin
    // Non-blocking, so the reset flops already wait for the falling edge
    {rstn_in, rd, wr, addr, wdata} <= '0;
    {errors, n_compared, gap, wid, cyc, seen, p_cs, p_sb} = '0;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_write();
    t_read();
    repeat (4) @(posedge clock_in);
    print_verdict();
  end
endmodule : parallel_flash_bus_timing_tb

// *** testbench/pfb_flash_model.sv ***
// Behavioural parallel flash chip facing the sequencer
`timescale 1ns/1ns
module pfb_flash_model #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 16
) (
  input  wire logic          cs_n_in,
  input  wire logic          rd_n_in,
  input  wire logic          wr_n_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          data_oe_in,
  output logic      [DW-1:0] data_out
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] last;
  // Preload a pattern so untouched words read back known
  initial
  begin
    last = '0;
    for (int i = 0; i < 2**AW; i++)
      mem[i] = DW'(16'hA500 ^ i);
  end
  // Drive only while selected and strobed; else the inverse of the last word
  always_comb
    data_out = (!cs_n_in && !rd_n_in) ? mem[addr_in] : ~last;
  // Remember what was last driven, so a stale bus never looks right
  always @(posedge rd_n_in)
    last = mem[addr_in];
  // Plain write cycle, no command decoding, stored as the strobe ends
  always @(posedge wr_n_in)
    if (!cs_n_in && data_oe_in)
      mem[addr_in] = data_in;
endmodule : pfb_flash_model
